// [bench/dcd_ctrl_model.sv]
// Memory controller stand-in: link clock and command pins.
// Assumes the bench calls drive once per link edge, clear of ck rise.
`timescale 1ns/1ps

// ==========================================
// Controller model
module dcd_ctrl_model (
  input wire core_clk,
  output reg ck,
  output reg cke,
  output reg cs_n,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg odt,
  output reg [2:0] ba,
  output reg [14:0] addr
);
  // Free-running link clock, phase unrelated to core_clk
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    odt = 1'b0;
    ba = 3'h0;
    addr = 15'h0000;
    ck = 1'b0;
    #7;
    forever #80 ck = ~ck;
  end
  // One command per link edge; sequences may break burst, bank and refresh windows
  task drive(input [4:0] p, input [2:0] b, input [14:0] a);
    begin
      @(posedge core_clk);
      {cke, cs_n, ras_n, cas_n, we_n} <= p;
      // Address lines are don't-care when idle, so they keep moving
      if (p[3] || p[2:0] == 3'h7) begin
        ba <= ~ba;
        addr <= ~addr;
      end else begin
        ba <= b;
        addr <= a;
      end
    end
  endtask
  // Termination request level
  task set_odt(input o);
    begin
      @(posedge core_clk);
      odt <= o;
    end
  endtask
endmodule

// [bench/dcd_top_chk.sv]
// Concurrent checks on the decoder top-level ports.
// Assumes it is bound into every dcd_top instance.
`timescale 1ns/1ps
`include "dcd_defs.vh"

// ==========================================
// Port checker
module dcd_top_chk #(
  parameter ADDR_W = `DCD_ADDR_W,
  parameter COL_HI = `DCD_COL_HI
) (
  input wire core_clk,
  input wire rst,
  input wire cke,
  input wire cs_n,
  input wire cmd_valid,
  input wire [`DCD_CMD_W-1:0] cmd_code,
  input wire cmd_illegal,
  input wire [ADDR_W-1:0] cmd_col,
  input wire cmd_auto_pre,
  input wire [`DCD_BA_W-1:0] mode_sel,
  input wire [ADDR_W-1:0] mode_opcode,
  input wire self_refresh,
  input wire power_down,
  input wire odt_on
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Column commands and their auto precharge forms
  wire ap_code;
  wire col_cmd;
  assign ap_code = cmd_code == `DCD_CMD_RD_AP || cmd_code == `DCD_CMD_WR_AP;
  assign col_cmd = cmd_valid && (ap_code || cmd_code == `DCD_CMD_RD || cmd_code == `DCD_CMD_WR);

  AST_ONE_PULSE: assert property (cmd_valid && cmd_code != `DCD_CMD_SR_EXIT |=> !cmd_valid)
    else $error("command report held too long");
  AST_SRX_CLEAR: assert property (cmd_valid && cmd_code == `DCD_CMD_SR_EXIT |-> !self_refresh && $past(self_refresh))
    else $error("self refresh exit reported out of self refresh");
  AST_ILL_QUAL: assert property (cmd_illegal |-> cmd_valid)
    else $error("illegal flag without a report");
  AST_NOP_LEGAL: assert property (cmd_valid && cmd_code <= `DCD_CMD_DESEL |-> !cmd_illegal)
    else $error("idle command refused");
  AST_COL_MASK: assert property (col_cmd |-> !cmd_col[`DCD_AP_BIT] && (cmd_col >> (COL_HI + 1)) == 0)
    else $error("column keeps ignored bits");
  AST_AP_FLAG: assert property (col_cmd |-> cmd_auto_pre == ap_code)
    else $error("auto precharge flag wrong");
  AST_MODE_HOLD: assert property ($changed(mode_sel) || $changed(mode_opcode) |->
    cmd_valid && cmd_code == `DCD_CMD_MODE && !cmd_illegal)
    else $error("mode fields moved without a mode load");
  AST_SR_ENTER: assert property (cmd_valid && cmd_code == `DCD_CMD_SR_ENTER && !cmd_illegal |-> ##[0:2] self_refresh)
    else $error("self refresh not entered");
  AST_PD_ENTER: assert property (cmd_valid && cmd_code == `DCD_CMD_PD_ENTER && !cmd_illegal |-> ##[0:2] power_down)
    else $error("power-down not entered");
  AST_SR_EXIT: assert property (self_refresh && cke && cs_n |-> ##[1:10] !self_refresh)
    else $error("self refresh not left");
  AST_ODT_SR: assert property (self_refresh && $past(self_refresh) |-> !odt_on)
    else $error("termination on in self refresh");
  COV_AP: cover property (col_cmd && ap_code);
  COV_ILL: cover property (cmd_valid && cmd_illegal);
  COV_SRX: cover property ($fell(self_refresh));
endmodule

bind dcd_top dcd_top_chk #(.ADDR_W(ADDR_W), .COL_HI(COL_HI)) dcd_top_chk_i (
  .core_clk(core_clk), .rst(rst), .cke(cke), .cs_n(cs_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_illegal(cmd_illegal), .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre), .mode_sel(mode_sel),
  .mode_opcode(mode_opcode), .self_refresh(self_refresh), .power_down(power_down), .odt_on(odt_on));

// [bench/test_ddr2_command_decode_bank_state.sv]
// Self-checking bench for the command decoder and bank tracker.
// Assumes dcd_top, its checker and the controller model are compiled first.
`timescale 1ns/1ps
`include "dcd_defs.vh"

// ==========================================
// Bench top
module test_ddr2_command_decode_bank_state;
  // Pin patterns {cke, cs_n, ras_n, cas_n, we_n}
  localparam [4:0] NOP = 5'h17;
  localparam [4:0] ACT = 5'h13;
  localparam [4:0] RD = 5'h15;
  localparam [4:0] WR = 5'h14;
  localparam [4:0] PRE = 5'h12;
  localparam [4:0] REF = 5'h11;
  localparam [4:0] MRS = 5'h10;
  reg core_clk;
  reg rst;
  integer errors;
  integer compares;
  integer cycles;
  integer n;
  wire ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  wire cmd_valid, cmd_illegal, cmd_auto_pre, all_banks_idle, self_refresh, power_down, odt_on;
  wire [3:0] cmd_code;
  wire [2:0] ba, cmd_bank, mode_sel;
  wire [14:0] addr, cmd_row, cmd_col, mode_opcode;
  wire [23:0] bank_state;

  dcd_ctrl_model dcd_ctrl_model_i (.core_clk(core_clk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr));
  dcd_top #(.T_RFC(4), .T_XSNR(4)) dcd_top_i (.core_clk(core_clk), .rst(rst), .ck(ck), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_illegal(cmd_illegal), .cmd_bank(cmd_bank),
    .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre), .mode_sel(mode_sel),
    .mode_opcode(mode_opcode), .bank_state(bank_state), .all_banks_idle(all_banks_idle),
    .self_refresh(self_refresh), .power_down(power_down), .odt_on(odt_on));

  // Core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Verdict and end of run
  task complete_run;
    begin
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Compare and count
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // Wait a bounded number of core cycles for a report
  task wait_valid(input integer lim);
    begin
      n = 0;
      while (cmd_valid !== 1'b1 && n < lim) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  // One link edge; m 1 expects no report, m 2 ignores it
  task skip(input [4:0] p, input integer m);
    begin
      dcd_ctrl_model_i.drive(p, 3'h0, 15'h0000);
      @(posedge ck);
      wait_valid(6);
      if (m == 1) check("no_report", cmd_valid, 1'b0);
    end
  endtask
  // One link edge with its report judged
  task step(input [4:0] p, input [2:0] b, input [14:0] a, input [3:0] ec, input ei);
    begin
      dcd_ctrl_model_i.drive(p, b, a);
      @(posedge ck);
      wait_valid(6);
      check("cmd_valid", cmd_valid, 1'b1);
      check("cmd_code", cmd_code, ec);
      check("cmd_illegal", cmd_illegal, ei);
    end
  endtask
  // Idle link edges
  task nops(input integer k);
    begin
      repeat (k) step(NOP, 3'h0, 15'h0000, `DCD_CMD_NOP, 1'b0);
    end
  endtask
  // Two open banks, burst interruption, bank-by-bank close
  task t_access;
    begin
      step(ACT, 3'h1, 15'h0123, `DCD_CMD_ACT, 1'b0);
      check("cmd_row", cmd_row, 15'h0123);
      step(RD, 3'h1, 15'h0010, `DCD_CMD_RD, 1'b1);
      step(ACT, 3'h3, 15'h0045, `DCD_CMD_ACT, 1'b0);
      step(RD, 3'h1, 15'h7010, `DCD_CMD_RD, 1'b0);
      check("cmd_col", cmd_col, 15'h0010);
      check("cmd_bank", cmd_bank, 3'h1);
      step(RD, 3'h1, 15'h0020, `DCD_CMD_RD, 1'b1);
      step(WR, 3'h1, 15'h0020, `DCD_CMD_WR, 1'b0);
      step(RD, 3'h1, 15'h0030, `DCD_CMD_RD, 1'b1);
      check("bank1_wr", bank_state[5:3], `DCD_BS_WRITE);
      step(RD, 3'h1, 15'h0030, `DCD_CMD_RD, 1'b0);
      step(5'h18, 3'h1, 15'h0000, `DCD_CMD_DESEL, 1'b0);
      step(PRE, 3'h1, 15'h0000, `DCD_CMD_PRE, 1'b0);
      nops(4);
      check("bank1_idle", bank_state[5:3], `DCD_BS_IDLE);
      check("bank3_open", bank_state[11:9], `DCD_BS_ACTIVE);
      step(PRE, 3'h3, 15'h0000, `DCD_CMD_PRE, 1'b0);
      nops(4);
      check("all_idle", all_banks_idle, 1'b1);
    end
  endtask
  // Auto precharge read, then precharge of every bank
  task t_autopre;
    begin
      step(ACT, 3'h2, 15'h0200, `DCD_CMD_ACT, 1'b0);
      nops(2);
      step(RD, 3'h2, 15'h0408, `DCD_CMD_RD_AP, 1'b0);
      check("auto_pre", cmd_auto_pre, 1'b1);
      step(ACT, 3'h5, 15'h0300, `DCD_CMD_ACT, 1'b0);
      nops(5);
      check("bank2_idle", bank_state[8:6], `DCD_BS_IDLE);
      step(PRE, 3'h5, 15'h0400, `DCD_CMD_PRE_ALL, 1'b0);
      nops(4);
      check("all_idle", all_banks_idle, 1'b1);
    end
  endtask
  // Mode load needs every bank idle; refresh blocks a following activate
  task t_global;
    begin
      step(ACT, 3'h0, 15'h0001, `DCD_CMD_ACT, 1'b0);
      step(MRS, 3'h2, 15'h0111, `DCD_CMD_MODE, 1'b1);
      nops(2);
      step(PRE, 3'h0, 15'h0000, `DCD_CMD_PRE, 1'b0);
      nops(4);
      step(MRS, 3'h6, 15'h05a5, `DCD_CMD_MODE, 1'b0);
      nops(2);
      check("mode_sel", mode_sel, 3'h6);
      check("mode_opcode", mode_opcode, 15'h05a5);
      step(REF, 3'h0, 15'h0000, `DCD_CMD_REF, 1'b0);
      step(ACT, 3'h0, 15'h0000, `DCD_CMD_ACT, 1'b1);
      nops(4);
      step(RD, 3'h1, 15'h0000, `DCD_CMD_RD, 1'b1);
    end
  endtask
  // Self refresh with termination, then power-down
  task t_power;
    begin
      dcd_ctrl_model_i.set_odt(1'b1);
      step(5'h01, 3'h0, 15'h0000, `DCD_CMD_SR_ENTER, 1'b0);
      skip(5'h07, 1);
      check("self_refresh", self_refresh, 1'b1);
      check("odt_on", odt_on, 1'b0);
      dcd_ctrl_model_i.drive(5'h1f, 3'h0, 15'h0000);
      wait_valid(12);
      check("cmd_code", cmd_code, `DCD_CMD_SR_EXIT);
      skip(NOP, 2);
      check("odt_on", odt_on, 1'b1);
      step(ACT, 3'h0, 15'h0000, `DCD_CMD_ACT, 1'b1);
      nops(4);
      step(ACT, 3'h0, 15'h0000, `DCD_CMD_ACT, 1'b0);
      nops(2);
      step(PRE, 3'h0, 15'h0000, `DCD_CMD_PRE, 1'b0);
      nops(4);
      step(5'h07, 3'h0, 15'h0000, `DCD_CMD_PD_ENTER, 1'b0);
      skip(5'h07, 2);
      check("power_down", power_down, 1'b1);
      step(NOP, 3'h0, 15'h0000, `DCD_CMD_PD_EXIT, 1'b0);
      step(NOP, 3'h0, 15'h0000, `DCD_CMD_NOP, 1'b0);
      check("power_down", power_down, 1'b0);
    end
  endtask
  // Hang guard in core cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  // Reset, settle cke, run the scenarios
  initial begin
    rst = 1'b1;
    errors = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    skip(NOP, 2);
    skip(NOP, 2);
    t_access;
    t_autopre;
    t_global;
    t_power;
    complete_run;
  end
endmodule

// [design/dcd_defs.vh]
// Shared constants for the DDR2 command decoder and bank state tracker.
// Assumes inclusion by bare name; definitions only.
`ifndef DCD_DEFS_VH
`define DCD_DEFS_VH

// =====================================================================
// Decoded command codes
`define DCD_CMD_W 4
`define DCD_CMD_NOP 4'h0
`define DCD_CMD_DESEL 4'h1
`define DCD_CMD_MODE 4'h2
`define DCD_CMD_REF 4'h3
`define DCD_CMD_SR_ENTER 4'h4
`define DCD_CMD_SR_EXIT 4'h5
`define DCD_CMD_PRE 4'h6
`define DCD_CMD_PRE_ALL 4'h7
`define DCD_CMD_ACT 4'h8
`define DCD_CMD_WR 4'h9
`define DCD_CMD_WR_AP 4'hA
`define DCD_CMD_RD 4'hB
`define DCD_CMD_RD_AP 4'hC
`define DCD_CMD_PD_ENTER 4'hD
`define DCD_CMD_PD_EXIT 4'hE
`define DCD_CMD_BAD 4'hF

// =====================================================================
// Strobe patterns {ras_n, cas_n, we_n} with chip select low
`define DCD_PAT_MODE 3'b000
`define DCD_PAT_REF 3'b001
`define DCD_PAT_PRE 3'b010
`define DCD_PAT_ACT 3'b011
`define DCD_PAT_WR 3'b100
`define DCD_PAT_RD 3'b101
`define DCD_PAT_NOP 3'b111

// =====================================================================
// Bank states
`define DCD_BS_W 3
`define DCD_BS_IDLE 3'h0
`define DCD_BS_ACTIVATING 3'h1
`define DCD_BS_ACTIVE 3'h2
`define DCD_BS_READ 3'h3
`define DCD_BS_WRITE 3'h4
`define DCD_BS_READ_AP 3'h5
`define DCD_BS_WRITE_AP 3'h6
`define DCD_BS_PRECHARGING 3'h7

// =====================================================================
// Geometry and timing defaults, timings in link clock edges
`define DCD_NUM_BANKS 8
`define DCD_BA_W 3
`define DCD_ADDR_W 15
`define DCD_AP_BIT 10
`define DCD_COL_HI 11
`define DCD_BURST_LEN 4
`define DCD_T_RCD 3
`define DCD_T_RP 3
`define DCD_T_WR 3
`define DCD_T_RFC 26
`define DCD_T_MRD 2
`define DCD_T_XSNR 28
`define DCD_CNT_W 8
`define DCD_SYNC_W 3

`endif

// [design/dcd_sync.v]
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs come from outside the core_clk domain.
`timescale 1ns/1ps

module dcd_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;

  // =====================================================================
  // Synchroniser chain, one filter per bit
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i]; // Change counts once two stages agree
          end
        end
      end
    end
  endgenerate

endmodule

// [design/dcd_top.v]
// DDR2 command decoder with per-bank command legality tracking.
// Assumes the controller drives pins from the link clock ck; the core
// clock samples ck through a synchroniser and acts on its rising edges.
`timescale 1ns/1ps
`include "dcd_defs.vh"

// Summary of operation
// - Commands come only from cs, ras, cas, we, cke at link clock rising edge.
// - ODT never affects decoding; termination is off during self refresh.
// - Third bank bit only counts on parts of 1Gb or larger.
// - Column address bits above the configured top bit are ignored.
// - Bank bits pick the bank, or the mode register during mode load.
// - Self refresh ends asynchronously on cke high with deselect or nop.
// - Length-4 bursts run to completion and are never interrupted.
// - Power-down does no internal refresh; controller limits its length.
// - Bank legality checks apply only with cke high twice, after exit delay.
// - Deselect and nop start nothing and let operations continue.
// - Idle bank takes activate, refresh, mode load; latter two need all idle.
// - Active bank takes read, write or precharge of one or all banks.
// - Read bank takes new read, write or precharge.
// - Write bank takes read, new write or precharge.
// - Bank becomes active after activate plus activate-to-column delay.
// - Read or write state lasts from burst start until burst ends.
// - A10 high on read or write schedules auto precharge; low keeps row open.
module dcd_top #(
  parameter ADDR_W = `DCD_ADDR_W,
  parameter COL_HI = `DCD_COL_HI,
  parameter HAS_BA2 = 1,
  parameter BURST_LEN = `DCD_BURST_LEN,
  parameter T_RCD = `DCD_T_RCD,
  parameter T_RP = `DCD_T_RP,
  parameter T_WR = `DCD_T_WR,
  parameter T_RFC = `DCD_T_RFC,
  parameter T_MRD = `DCD_T_MRD,
  parameter T_XSNR = `DCD_T_XSNR,
  parameter CNT_W = `DCD_CNT_W
) (
  input wire core_clk,
  input wire rst,
  input wire ck,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire odt,
  input wire [`DCD_BA_W-1:0] ba,
  input wire [ADDR_W-1:0] addr,
  output reg cmd_valid,
  output reg [`DCD_CMD_W-1:0] cmd_code,
  output reg cmd_illegal,
  output reg [`DCD_BA_W-1:0] cmd_bank,
  output reg [ADDR_W-1:0] cmd_row,
  output reg [ADDR_W-1:0] cmd_col,
  output reg cmd_auto_pre,
  output reg [`DCD_BA_W-1:0] mode_sel,
  output reg [ADDR_W-1:0] mode_opcode,
  output reg [`DCD_NUM_BANKS*`DCD_BS_W-1:0] bank_state,
  output reg all_banks_idle,
  output reg self_refresh,
  output reg power_down,
  output reg odt_on
);

  localparam NB = `DCD_NUM_BANKS;
  localparam SW = `DCD_BS_W;
  localparam SYW = 7 + `DCD_BA_W + ADDR_W;
  localparam BURST_CK = BURST_LEN / 2;
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [CNT_W-1:0] LD_ACT = T_RCD[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_BURST = BURST_CK[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_RD_AP = BURST_CK[CNT_W-1:0] + T_RP[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_WR_AP = BURST_CK[CNT_W-1:0] + T_WR[CNT_W-1:0] + T_RP[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_PRE = T_RP[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_RFC = T_RFC[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_MRD = T_MRD[CNT_W-1:0] - CNT_ONE;
  localparam [CNT_W-1:0] LD_XSNR = T_XSNR[CNT_W-1:0];

  // =====================================================================
  // Pin synchronisation, all pins share one delay so they stay aligned
  wire [SYW-1:0] pins_q;
  wire ck_q, cke_q, cs_q, ras_q, cas_q, we_q, odt_q;
  wire [`DCD_BA_W-1:0] ba_q;
  wire [ADDR_W-1:0] addr_q;

  dcd_sync #(.W(SYW)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr}),
    .q(pins_q)
  );
  assign {ck_q, cke_q, cs_q, ras_q, cas_q, we_q, odt_q, ba_q, addr_q} = pins_q;
  reg ck_prev, cke_last;
  reg [CNT_W-1:0] ref_cnt, mrd_cnt, xsnr_cnt;
  wire ck_rise = ck_q & ~ck_prev;

  // =====================================================================
  // Command decode from sampled levels
  wire [2:0] pat = {ras_q, cas_q, we_q};
  wire quiet = cs_q | (pat == `DCD_PAT_NOP);
  wire ap = addr_q[`DCD_AP_BIT];
  wire [`DCD_BA_W-1:0] sel_bank = HAS_BA2 ? ba_q : {1'b0, ba_q[`DCD_BA_W-2:0]};
  wire table_on = cke_last & cke_q & (xsnr_cnt == CNT_ZERO);
  wire glob_busy = (ref_cnt != CNT_ZERO) | (mrd_cnt != CNT_ZERO);
  wire [NB*SW-1:0] eff;
  wire [NB-1:0] col_ok, act_ok, pre_ok, idle_b;
  reg [`DCD_CMD_W-1:0] next_code;
  reg next_ok;

  // Decode the command and its legality against the target bank
  always @* begin
    next_code = `DCD_CMD_BAD;
    next_ok = 1'b0;
    if (cke_last && !cke_q) begin
      if (quiet) begin
        next_code = `DCD_CMD_PD_ENTER;
        next_ok = 1'b1;
      end else if (pat == `DCD_PAT_REF) begin
        next_code = `DCD_CMD_SR_ENTER;
        next_ok = (&idle_b) & ~glob_busy;
      end
    end else if (!cke_last && cke_q) begin
      next_code = `DCD_CMD_PD_EXIT;
      next_ok = power_down & quiet;
    end else if (cke_last && cke_q) begin
      if (cs_q) begin
        next_code = `DCD_CMD_DESEL;
        next_ok = 1'b1;
      end else begin
        case (pat)
          `DCD_PAT_NOP: begin
            next_code = `DCD_CMD_NOP;
            next_ok = 1'b1;
          end
          `DCD_PAT_MODE: begin
            next_code = `DCD_CMD_MODE;
            next_ok = (&idle_b) & ~glob_busy;
          end
          `DCD_PAT_REF: begin
            next_code = `DCD_CMD_REF;
            next_ok = (&idle_b) & ~glob_busy;
          end
          `DCD_PAT_ACT: begin
            next_code = `DCD_CMD_ACT;
            next_ok = act_ok[sel_bank] & ~glob_busy;
          end
          `DCD_PAT_PRE: begin
            next_code = ap ? `DCD_CMD_PRE_ALL : `DCD_CMD_PRE;
            next_ok = (ap ? (&pre_ok) : pre_ok[sel_bank]) & ~glob_busy;
          end
          `DCD_PAT_RD: begin
            next_code = ap ? `DCD_CMD_RD_AP : `DCD_CMD_RD;
            next_ok = col_ok[sel_bank] & ~glob_busy;
          end
          `DCD_PAT_WR: begin
            next_code = ap ? `DCD_CMD_WR_AP : `DCD_CMD_WR;
            next_ok = col_ok[sel_bank] & ~glob_busy;
          end
          default: begin
            next_code = `DCD_CMD_BAD;
            next_ok = 1'b0;
          end
        endcase
      end
      if (!quiet && !table_on) begin
        next_ok = 1'b0;
      end
    end
  end

  wire exec = ck_rise & next_ok & ~self_refresh;
  wire sr_exit = self_refresh & cke_q & quiet;

  // =====================================================================
  // Per-bank state tracking
  genvar i;
  generate
    for (i = 0; i < NB; i = i + 1) begin : g_bank
      reg [SW-1:0] st, res;
      reg [CNT_W-1:0] cnt;
      wire hit = (sel_bank == i);
      wire done = (cnt == CNT_ZERO);
      wire burst_end = (st == `DCD_BS_READ) | (st == `DCD_BS_WRITE);

      // Resolve timed states whose delay has run out on this edge
      always @* begin
        res = st;
        if (done) begin
          case (st)
            `DCD_BS_ACTIVATING: res = `DCD_BS_ACTIVE;
            `DCD_BS_PRECHARGING: res = `DCD_BS_IDLE;
            `DCD_BS_READ_AP: res = `DCD_BS_IDLE;
            `DCD_BS_WRITE_AP: res = `DCD_BS_IDLE;
            default: res = st;
          endcase
        end
      end

      assign eff[i*SW +: SW] = res;
      assign idle_b[i] = (res == `DCD_BS_IDLE);
      assign act_ok[i] = (res == `DCD_BS_IDLE);
      assign col_ok[i] = (res == `DCD_BS_ACTIVE) | (burst_end & done);
      assign pre_ok[i] = (res == `DCD_BS_IDLE) | col_ok[i];

      // Apply legal commands and advance delay counters
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          st <= `DCD_BS_IDLE;
          cnt <= CNT_ZERO;
        end else if (ck_rise) begin
          if (exec && hit && next_code == `DCD_CMD_ACT) begin
            st <= `DCD_BS_ACTIVATING;
            cnt <= LD_ACT;
          end else if (exec && hit && next_code == `DCD_CMD_RD) begin
            st <= `DCD_BS_READ;
            cnt <= LD_BURST;
          end else if (exec && hit && next_code == `DCD_CMD_WR) begin
            st <= `DCD_BS_WRITE;
            cnt <= LD_BURST;
          end else if (exec && hit && next_code == `DCD_CMD_RD_AP) begin
            st <= `DCD_BS_READ_AP;
            cnt <= LD_RD_AP;
          end else if (exec && hit && next_code == `DCD_CMD_WR_AP) begin
            st <= `DCD_BS_WRITE_AP;
            cnt <= LD_WR_AP;
          end else if (exec && !idle_b[i] && ((hit && next_code == `DCD_CMD_PRE) ||
                                              next_code == `DCD_CMD_PRE_ALL)) begin
            st <= `DCD_BS_PRECHARGING;
            cnt <= LD_PRE;
          end else begin
            if (burst_end && done) begin
              st <= `DCD_BS_ACTIVE;
            end else begin
              st <= res;
            end
            if (!done) begin
              cnt <= cnt - CNT_ONE;
            end
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // Global delays, power modes and link clock edge history
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ck_prev <= 1'b0;
      cke_last <= 1'b0;
      ref_cnt <= CNT_ZERO;
      mrd_cnt <= CNT_ZERO;
      xsnr_cnt <= CNT_ZERO;
      self_refresh <= 1'b0;
      power_down <= 1'b0;
    end else begin
      ck_prev <= ck_q;
      if (sr_exit) begin
        self_refresh <= 1'b0;
        xsnr_cnt <= LD_XSNR;
      end
      if (ck_rise) begin
        cke_last <= cke_q;
        if (ref_cnt != CNT_ZERO) begin
          ref_cnt <= ref_cnt - CNT_ONE;
        end
        if (mrd_cnt != CNT_ZERO) begin
          mrd_cnt <= mrd_cnt - CNT_ONE;
        end
        if (!sr_exit && xsnr_cnt != CNT_ZERO && !self_refresh) begin
          xsnr_cnt <= xsnr_cnt - CNT_ONE;
        end
        if (exec) begin
          case (next_code)
            `DCD_CMD_REF: ref_cnt <= LD_RFC;
            `DCD_CMD_MODE: mrd_cnt <= LD_MRD;
            `DCD_CMD_SR_ENTER: self_refresh <= 1'b1;
            `DCD_CMD_PD_ENTER: power_down <= 1'b1;
            `DCD_CMD_PD_EXIT: power_down <= 1'b0;
            default: power_down <= power_down;
          endcase
        end
      end
    end
  end

  // =====================================================================
  // Registered command report and status outputs
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= `DCD_CMD_NOP;
      cmd_illegal <= 1'b0;
      cmd_bank <= {`DCD_BA_W{1'b0}};
      cmd_row <= {ADDR_W{1'b0}};
      cmd_col <= {ADDR_W{1'b0}};
      cmd_auto_pre <= 1'b0;
      mode_sel <= {`DCD_BA_W{1'b0}};
      mode_opcode <= {ADDR_W{1'b0}};
      bank_state <= {NB*SW{1'b0}};
      all_banks_idle <= 1'b1;
      odt_on <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      cmd_illegal <= 1'b0;
      bank_state <= eff;
      all_banks_idle <= &idle_b;
      odt_on <= odt_q & ~self_refresh;
      if (sr_exit) begin
        cmd_valid <= 1'b1;
        cmd_code <= `DCD_CMD_SR_EXIT;
      end else if (ck_rise && !self_refresh) begin
        cmd_valid <= 1'b1;
        cmd_code <= next_code;
        cmd_illegal <= ~next_ok;
        cmd_bank <= sel_bank;
        cmd_row <= addr_q;
        cmd_auto_pre <= ap & (pat == `DCD_PAT_RD || pat == `DCD_PAT_WR);
        cmd_col <= addr_q & ~({ADDR_W{1'b1}} << (COL_HI + 1)) & ~({{(ADDR_W-1){1'b0}}, 1'b1} << `DCD_AP_BIT);
        if (exec && next_code == `DCD_CMD_MODE) begin
          mode_sel <= ba_q;
          mode_opcode <= addr_q;
        end
      end
    end
  end

endmodule
